// *** shared/ecoi_pkg.sv ***
// Package for the eight-channel output image block: offsets, widths, timing.
// Assumes a single 250 MHz clock and a byte-wide output image write port.
package ecoi_pkg;
    localparam int          CLK_HZ          = 250_000_000;
    localparam int          BLINK_HZ        = 2;
    // Half period of the blink toggles the lamp phase
    localparam int          BLINK_HALF_CYC  = CLK_HZ / (2 * BLINK_HZ);
    localparam int          NUM_CH          = 8;
    localparam logic [0:0]  OUT_IMAGE_OFS   = 1'h0;
    localparam logic [7:0]  OUT_IMAGE_RST   = 8'h00;

    typedef struct packed {
        logic bus_ok;
        logic module_err;
        logic supply_fail;
        logic config_err;
    } ecoi_health_t;

    typedef struct packed {
        logic run;
        logic fault;
    } ecoi_lamps_t;
endpackage

// *** design/ecoi_output_image.sv ***
// Eight-channel output image: one written byte drives eight outputs and lamps.
// Assumes the write port shares i_clk; health inputs are pins of other domains.
`timescale 1ns/1ps
`default_nettype none
module ecoi_output_image #(
    parameter int BLINK_HALF = ecoi_pkg::BLINK_HALF_CYC
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_wr_en,
    input  wire logic [0:0]            i_wr_addr,
    input  wire logic [7:0]            i_wr_data,
    input  wire ecoi_pkg::ecoi_health_t i_health,
    output logic [7:0]                 o_outputs,
    output logic [7:0]                 o_ch_lamps,
    output ecoi_pkg::ecoi_lamps_t      o_lamps
);
    import ecoi_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Health pins pass two flops; write port is same-domain logic
    ecoi_health_t h_s1_q, h_s1_d;
    ecoi_health_t h_s2_q, h_s2_d;

    // Reset reads as bus down, so the fault lamp shows until the pins are seen
    always_comb begin
        h_s1_d = i_health;
        h_s2_d = h_s1_q; // Nothing else reads the first flop
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            h_s1_q <= '0;
            h_s2_q <= '0;
        end else begin
            h_s1_q <= h_s1_d;
            h_s2_q <= h_s2_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output image byte
    logic [7:0] image_q, image_d;
    always_comb begin
        image_d = image_q;
        if (i_wr_en && i_wr_addr == OUT_IMAGE_OFS) begin
            image_d = i_wr_data;
        end
        // Writes to any other offset fall through and leave the byte alone
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            image_q <= OUT_IMAGE_RST;
        end else begin
            image_q <= image_d;
        end
    end

    // No read path exists: the block contributes nothing to the input area
    // Output bits and their lamps share one flop each, so they cannot disagree
    for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
        assign o_outputs[n]  = image_q[n];
        assign o_ch_lamps[n] = image_q[n];
        ch_take_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
            i_wr_en && i_wr_addr == OUT_IMAGE_OFS |=> o_outputs[n] == $past(i_wr_data[n]))
            else $error("channel bit not taken from its data bit");
    end

    ////////////////////////////////////////////////////////////////////////
    // Blink divider, 2 Hz square wave
    logic [27:0] blink_cnt_q, blink_cnt_d;
    logic        phase_q, phase_d;
    always_comb begin
        blink_cnt_d = blink_cnt_q + 28'h000_0001;
        phase_d     = phase_q;
        if (blink_cnt_q >= 28'(BLINK_HALF - 1)) begin
            blink_cnt_d = 28'h000_0000;
            phase_d     = ~phase_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            blink_cnt_q <= 28'h000_0000;
            phase_q     <= 1'b0;
        end else begin
            blink_cnt_q <= blink_cnt_d;
            phase_q     <= phase_d;
        end
    end

    // Watch-side age of the lamp phase, kept apart from the divider so the rate
    // check does not just restate the divider's own compare
    logic        phase_last_q, phase_last_d;
    logic [27:0] phase_age_q, phase_age_d;

    always_comb begin
        phase_last_d = phase_q;
        phase_age_d  = phase_age_q + 28'h000_0001;
        if (phase_q != phase_last_q) begin
            phase_age_d = 28'h000_0000;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            phase_last_q <= 1'b0;
            phase_age_q  <= 28'h000_0000;
        end else begin
            phase_last_q <= phase_last_d;
            phase_age_q  <= phase_age_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lamp decode; supply failure outranks everything since lamps lose power
    ecoi_lamps_t lamps_q, lamps_d;
    always_comb begin
        if (h_s2_q.supply_fail) begin
            lamps_d = '{run: 1'b0, fault: 1'b0};
        end else if (h_s2_q.config_err) begin
            lamps_d = '{run: phase_q, fault: phase_q};
        end else if (!h_s2_q.bus_ok) begin
            lamps_d = '{run: 1'b0, fault: 1'b1};
        end else if (h_s2_q.module_err) begin
            lamps_d = '{run: 1'b1, fault: 1'b1};
        end else begin
            lamps_d = '{run: 1'b1, fault: 1'b0};
        end
    end

    // One more register keeps the lamps clean while the decode inputs settle
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            lamps_q <= '0;
        end else begin
            lamps_q <= lamps_d;
        end
    end
    assign o_lamps = lamps_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Reset disables all but lamp_follow_a and the check that watches reset itself
    write_takes_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_wr_en && i_wr_addr == OUT_IMAGE_OFS |=> o_outputs == $past(i_wr_data))
        else $error("output byte not taken");

    addr_ignored_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_wr_en && i_wr_addr != OUT_IMAGE_OFS |=> $stable(o_outputs))
        else $error("write to unmapped offset changed outputs");

    hold_image_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_wr_en |=> $stable(o_outputs))
        else $error("outputs changed without write");

    lamp_follow_a: assert property (@(posedge i_clk)
        o_ch_lamps == o_outputs)
        else $error("channel lamp differs from output");

    reset_off_a: assert property (@(posedge i_clk)
        !i_resetn |=> o_outputs == 8'h00)
        else $error("outputs not off after reset");

    // Lamp checks take the synchronised health, one register ahead of the lamps,
    // so this one pins down what that health is
    sync_delay_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $past(i_resetn, 2) |-> h_s2_q == $past(i_health, 2))
        else $error("health synchroniser delay wrong");

    run_ok_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        h_s2_q.bus_ok && !h_s2_q.module_err && !h_s2_q.supply_fail && !h_s2_q.config_err
        |=> o_lamps.run && !o_lamps.fault)
        else $error("healthy lamps wrong");

    mod_err_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        h_s2_q.bus_ok && h_s2_q.module_err && !h_s2_q.supply_fail && !h_s2_q.config_err
        |=> o_lamps.run && o_lamps.fault)
        else $error("module error lamps wrong");

    bus_down_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !h_s2_q.bus_ok && !h_s2_q.supply_fail && !h_s2_q.config_err
        |=> !o_lamps.run && o_lamps.fault)
        else $error("bus down lamps wrong");

    supply_dark_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        h_s2_q.supply_fail |=> o_lamps == '0)
        else $error("lamps lit on supply failure");

    blink_sync_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        h_s2_q.config_err && !h_s2_q.supply_fail |=> o_lamps.run == o_lamps.fault)
        else $error("config blink not together");

    blink_phase_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        h_s2_q.config_err && !h_s2_q.supply_fail |=> o_lamps.run == $past(phase_q))
        else $error("config lamps not on blink phase");

    blink_bound_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        blink_cnt_q < 28'(BLINK_HALF))
        else $error("blink divider ran past its half period");

    // The first half period after reset reads one longer, as the age starts
    // counting at the reset phase rather than at a toggle
    blink_slow_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        phase_age_q <= 28'(BLINK_HALF))
        else $error("blink phase held too long");

    blink_fast_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        phase_q != phase_last_q |-> phase_age_q >= 28'(BLINK_HALF - 1))
        else $error("blink phase toggled too soon");
endmodule
`default_nettype wire

// *** test/ecoi_bus_master.sv ***
// Bus master model: issues single byte writes to the output image.
// Assumes the bench calls write_byte only after reset is released.
`timescale 1ns/1ps
`default_nettype none
module ecoi_bus_master (
    input  wire logic       i_clk,
    output logic            o_wr_en,
    output logic [0:0]      o_wr_addr,
    output logic [7:0]      o_wr_data
);
    initial o_wr_en = 1'b0;
    initial o_wr_addr = 1'h1;
    initial o_wr_data = 8'h00;
    task automatic write_byte(input logic [0:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_wr_en = 1'b1;
        o_wr_addr = a;
        o_wr_data = d;
        @(posedge i_clk);
        #1;
        // Idle bus shows no stale byte
        o_wr_en = 1'b0;
        o_wr_addr = ~a;
        o_wr_data = ~d;
    endtask
endmodule
`default_nettype wire

// *** test/ecoi_output_image_tb_top.sv ***
// Bench for the output image block: byte writes and lamp states.
// Assumes a shortened blink half period.
`timescale 1ns/1ps
`default_nettype none
module ecoi_output_image_tb_top;
    import ecoi_pkg::*;
    localparam int HALF = 4;
    logic         clk = 1'b0;
    logic         resetn = 1'b0;
    logic         wr_en;
    logic [0:0]   wr_addr;
    logic [7:0]   wr_data;
    logic [7:0]   outs;
    logic [7:0]   chl;
    ecoi_health_t health = 4'h8;
    ecoi_lamps_t  lamps;
    int           bad_count = 0;
    int           tests_run = 0;
    always #2 clk = ~clk;
    ecoi_bus_master i_master (.i_clk(clk), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
    ecoi_output_image #(.BLINK_HALF(HALF)) i_dut (.i_clk(clk), .i_resetn(resetn), .i_wr_en(wr_en),
        .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_health(health), .o_outputs(outs),
        .o_ch_lamps(chl), .o_lamps(lamps));
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp_byte(input logic [7:0] e);
        tests_run++;
        if ({outs, chl} !== {e, e}) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, {outs, chl}, {e, e});
        end
    endtask
    task automatic cmp_lamps(input ecoi_lamps_t g, input ecoi_lamps_t e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Four edges cover the two-flop synchroniser plus the lamp register
    task automatic check_health(input ecoi_health_t h, input ecoi_lamps_t e);
        health = h;
        repeat (4) @(posedge clk);
        #1;
        cmp_lamps(lamps, e);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        #1;
        resetn = 1'b1;
        cmp_byte(8'h00);
        for (int n = 0; n < NUM_CH; n++) begin
            i_master.write_byte(1'h0, 8'h01 << n);
            cmp_byte(8'h01 << n);
        end
        i_master.write_byte(1'h1, 8'h3C);
        cmp_byte(8'h80);
        i_master.write_byte(1'h0, 8'hA5);
        cmp_byte(8'hA5);
        check_health(4'h8, 2'h2);
        check_health(4'hC, 2'h3);
        check_health(4'h4, 2'h1);
        check_health(4'hA, 2'h0);
        check_health(4'hB, 2'h0);
        // Time one lit half period from its first edge: HALF edges lit, then dark
        health = 4'h9;
        repeat (4) @(posedge clk);
        #1;
        for (int k = 0; k < 2 * HALF && lamps !== 2'h0; k++) begin
            @(posedge clk);
            #1;
        end
        for (int k = 0; k < 2 * HALF && lamps !== 2'h3; k++) begin
            @(posedge clk);
            #1;
        end
        cmp_lamps(lamps, 2'h3);
        repeat (HALF - 1) @(posedge clk);
        #1;
        cmp_lamps(lamps, 2'h3);
        @(posedge clk);
        #1;
        cmp_lamps(lamps, 2'h0);
        // A reset in mid-run clears the byte again until the next write
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        cmp_byte(8'h00);
        i_master.write_byte(1'h0, 8'h5A);
        cmp_byte(8'h5A);
        stop_test();
    end
    // Tests need some 65 cycles; this is about seventy-five times that
    initial begin
        #20000;
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
